/* File: common/swk_pkg.sv */
// Register map, field layout and timing constants of the selective-wake registers
package swk_pkg;
    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [6:0] ADDR_PAYLOAD3 = 7'h30;
    localparam logic [6:0] ADDR_PAYLOAD2 = 7'h31;
    localparam logic [6:0] ADDR_PAYLOAD1 = 7'h32;
    localparam logic [6:0] ADDR_PAYLOAD0 = 7'h33;
    localparam logic [3:0][6:0] ADDR_PAYLOAD = {ADDR_PAYLOAD3, ADDR_PAYLOAD2, ADDR_PAYLOAD1, ADDR_PAYLOAD0};
    localparam logic [6:0] ADDR_FD_CTRL = 7'h34;
    localparam logic [6:0] ADDR_FINE_TRIM = 7'h38;
    localparam logic [6:0] ADDR_OPTIONS = 7'h39;
    localparam logic [6:0] ADDR_CAL_HIGH = 7'h3a;
    localparam logic [6:0] ADDR_CAL_LOW = 7'h3b;

    // ************************************************************
    // Field positions and values
    // ************************************************************
    localparam int FD_EN_BIT = 0;
    localparam int FILT_LSB = 1;
    localparam int FILT_MSB = 3;
    localparam int BYPASS_BIT = 4;
    localparam int ERR_DIS_BIT = 5;
    localparam int RX_SEL_BIT = 7;
    localparam int COARSE_MSB = 4;
    localparam logic [1:0] TRIM_UNLOCK = 2'h3;
    localparam logic [7:0] BYTE_CLEAR = 8'h00;
    localparam logic [2:0] FILT_LONG_CODE = 3'h7;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int FILT_STEP_NS = 50;
    localparam int FILT_LONG_NS = 775;
    localparam int FILT_CNT_W = 8;
    localparam int FILT_LONG_CYC = (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : swk_pkg

/* File: common/swk_cfg_if.sv */
// Configuration bundle passed from the register file to the frame snapshot
`timescale 1ns/100ps
`default_nettype none
interface swk_cfg_if;
    logic [3:0][7:0] payload;
    logic fd_en;
    logic [2:0] filt_code;
    logic [swk_pkg::FILT_CNT_W-1:0] filt_cycles;
    logic bypass;
    logic err_dis;

    modport regs (output payload, output fd_en, output filt_code, output bypass, output err_dis);
    modport map (input filt_code, output filt_cycles);
    modport snap (input payload, input fd_en, input filt_cycles, input bypass, input err_dis);
endinterface : swk_cfg_if
`default_nettype wire

/* File: logic/swk_filt_map.sv */
// Dominant filter code to clock-cycle count
`timescale 1ns/100ps
`default_nettype none
module swk_filt_map (
    // Configuration
    swk_cfg_if.map cfg
);
    int filt_ns;

    always_comb begin
        if (cfg.filt_code == swk_pkg::FILT_LONG_CODE) begin
            filt_ns = swk_pkg::FILT_LONG_NS;
        end else begin
            filt_ns = swk_pkg::FILT_STEP_NS * (int'(cfg.filt_code) + 1);
        end
        // Filter is a least time, so round up
        cfg.filt_cycles = swk_pkg::FILT_CNT_W'((filt_ns + swk_pkg::CLK_PERIOD_NS - 1) / swk_pkg::CLK_PERIOD_NS);
    end
endmodule : swk_filt_map
`default_nettype wire

/* File: logic/swk_frame_snap.sv */
// Per-frame snapshot of the wake comparison settings
`timescale 1ns/100ps
`default_nettype none
module swk_frame_snap (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic soft_rst_i,
    // Frame control
    input wire logic frame_start_i,
    swk_cfg_if.snap cfg,
    // Active settings
    output logic [31:0] active_payload_o,
    output logic active_fd_en_o,
    output logic [swk_pkg::FILT_CNT_W-1:0] active_filt_cycles_o,
    output logic active_bypass_o,
    output logic active_err_cnt_o
);
    typedef struct packed {
        logic [31:0] payload;
        logic fd_en;
        logic [swk_pkg::FILT_CNT_W-1:0] cycles;
        logic bypass;
        logic err_cnt;
    } swk_snap_type;

    swk_snap_type snap_q;
    swk_snap_type snap_d;

    always_comb begin
        snap_d = snap_q;
        if (frame_start_i) begin
            snap_d.payload = cfg.payload;
            snap_d.fd_en = cfg.fd_en;
            snap_d.cycles = cfg.filt_cycles;
            snap_d.bypass = cfg.bypass;
            snap_d.err_cnt = !(cfg.err_dis && cfg.fd_en);
        end
        if (soft_rst_i) begin
            snap_d = '0;
            snap_d.err_cnt = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            snap_q <= '0;
            snap_q.err_cnt <= 1'b1;
        end else if (ce_i) begin
            snap_q <= snap_d;
        end
    end

    assign active_payload_o = snap_q.payload;
    assign active_fd_en_o = snap_q.fd_en;
    assign active_filt_cycles_o = snap_q.cycles;
    assign active_bypass_o = snap_q.bypass;
    assign active_err_cnt_o = snap_q.err_cnt;
endmodule : swk_frame_snap
`default_nettype wire

/* File: logic/swk_regs.sv */
// Selective-wake payload, FD tolerance, trim and calibration registers
//
// What this block does
// - Four payload registers each hold one read-write wake data byte, bit 0 LSB.
// - Reserved FD control and options bits ignore writes and read as zero.
// - FD control bit 0 enables FD tolerant mode.
// - Filter code selects 50 ns to 350 ns in 50 ns steps, code 7 775 ns.
// - Error counter disabled during wake only when bit 5 and FD mode both set.
// - Bus silence timeout clears the error counter disable bit unless FD control is written in the same cycle.
// - Bit 4 bypasses analog receive filter; digital filter time still applies.
// - Fine trim and coarse trim accept writes only while trim enable is 11.
// - Low five fine trim bits form a monotonic 32-step frequency adjustment.
// - Options bit 7 selects standard or low-power wake receiver, trim enable 11 only.
// - Options bits 4 to 0 hold the non-monotonic 32-step coarse trim.
// - Calibration-high register is a read-only upper calibration byte.
// - Payload, FD control and calibration clear to zero on reset or soft reset.
// - Calibration-low register is a read-only lower calibration byte.
`timescale 1ns/100ps
`default_nettype none
module swk_regs #(
    parameter logic [7:0] FINE_TRIM_RST = 8'h00,
    parameter logic [4:0] COARSE_TRIM_RST = 5'h00,
    parameter logic RX_SEL_RST = 1'b0
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic soft_rst_i,
    // Register port
    input wire logic [6:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Device status and events
    input wire logic [1:0] trim_en_i,
    input wire logic silence_timeout_i,
    input wire logic frame_start_i,
    input wire logic [7:0] cal_high_i,
    input wire logic [7:0] cal_low_i,
    // Wake comparison settings
    output logic [31:0] wake_payload_o,
    output logic fd_tolerant_enable_o,
    output logic [swk_pkg::FILT_CNT_W-1:0] dominant_filter_cycles_o,
    output logic analog_rx_filter_bypass_o,
    output logic error_counter_active_o,
    // Oscillator and receiver
    output logic [12:0] osc_trim_o,
    output logic wake_receiver_select_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [3:0][7:0] payload;
        logic err_dis;
        logic bypass;
        logic [2:0] filt;
        logic fd_en;
        logic [7:0] fine;
        logic rx_sel;
        logic [4:0] coarse;
        logic [7:0] cal_h;
        logic [7:0] cal_l;
        logic [7:0] rdata;
    } swk_regs_type;

    swk_regs_type reg_q;
    swk_regs_type reg_d;
    logic [3:0] pay_hit;
    logic fd_hit;
    logic fine_hit;
    logic opt_hit;
    logic unlocked;
    logic [7:0] rd_val;

    swk_cfg_if cfg ();

    // ************************************************************
    // Address decode
    // ************************************************************
    // Strobes decoded alone; ce_i gates only the state update
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pay
            assign pay_hit[gi] = reg_wr_i && (reg_addr_i == swk_pkg::ADDR_PAYLOAD[gi]);
        end
    endgenerate

    assign fd_hit = reg_wr_i && (reg_addr_i == swk_pkg::ADDR_FD_CTRL);
    assign fine_hit = reg_wr_i && (reg_addr_i == swk_pkg::ADDR_FINE_TRIM);
    assign opt_hit = reg_wr_i && (reg_addr_i == swk_pkg::ADDR_OPTIONS);
    assign unlocked = (trim_en_i == swk_pkg::TRIM_UNLOCK);

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb begin
        // Unmapped addresses read as zero
        rd_val = swk_pkg::BYTE_CLEAR;
        for (int i = 0; i < 4; i++) begin
            if (reg_addr_i == swk_pkg::ADDR_PAYLOAD[i]) begin
                rd_val = reg_q.payload[i];
            end
        end
        case (reg_addr_i)
            swk_pkg::ADDR_FD_CTRL: begin
                rd_val = {2'h0, reg_q.err_dis, reg_q.bypass, reg_q.filt, reg_q.fd_en};
            end
            swk_pkg::ADDR_FINE_TRIM: begin
                rd_val = reg_q.fine;
            end
            swk_pkg::ADDR_OPTIONS: begin
                rd_val = {reg_q.rx_sel, 2'h0, reg_q.coarse};
            end
            swk_pkg::ADDR_CAL_HIGH: begin
                rd_val = reg_q.cal_h;
            end
            swk_pkg::ADDR_CAL_LOW: begin
                rd_val = reg_q.cal_l;
            end
            default: begin
            end
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        reg_d = reg_q;
        // Calibration tracks its inputs every enabled cycle without soft reset
        reg_d.cal_h = cal_high_i;
        reg_d.cal_l = cal_low_i;
        for (int i = 0; i < 4; i++) begin
            if (pay_hit[i]) begin
                reg_d.payload[i] = reg_wdata_i;
            end
        end
        if (fd_hit) begin
            reg_d.fd_en = reg_wdata_i[swk_pkg::FD_EN_BIT];
            reg_d.filt = reg_wdata_i[swk_pkg::FILT_MSB:swk_pkg::FILT_LSB];
            reg_d.bypass = reg_wdata_i[swk_pkg::BYPASS_BIT];
            reg_d.err_dis = reg_wdata_i[swk_pkg::ERR_DIS_BIT];
        end else if (silence_timeout_i) begin
            reg_d.err_dis = 1'b0;
        end
        if (fine_hit && unlocked) begin
            reg_d.fine = reg_wdata_i;
        end
        if (opt_hit && unlocked) begin
            reg_d.rx_sel = reg_wdata_i[swk_pkg::RX_SEL_BIT];
            reg_d.coarse = reg_wdata_i[swk_pkg::COARSE_MSB:0];
        end
        // Read data registered so the port sees a flop
        if (reg_rd_i) begin
            reg_d.rdata = rd_val;
        end
        if (soft_rst_i) begin
            reg_d.payload = '0;
            reg_d.fd_en = 1'b0;
            reg_d.filt = 3'h0;
            reg_d.bypass = 1'b0;
            reg_d.err_dis = 1'b0;
            reg_d.cal_h = swk_pkg::BYTE_CLEAR;
            reg_d.cal_l = swk_pkg::BYTE_CLEAR;
            // Trim and receiver select survive soft reset
        end
    end

    // Trim reset values are parameters since they are left undefined
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_q <= '0;
            reg_q.fine <= FINE_TRIM_RST;
            reg_q.coarse <= COARSE_TRIM_RST;
            reg_q.rx_sel <= RX_SEL_RST;
        end else if (ce_i) begin
            reg_q <= reg_d;
        end
    end

    // ************************************************************
    // Outputs and submodules
    // ************************************************************
    assign reg_rdata_o = reg_q.rdata;
    // fine in low bits, coarse above
    assign osc_trim_o = {reg_q.coarse, reg_q.fine};
    assign wake_receiver_select_o = reg_q.rx_sel;

    // Live register values; the snapshot decides what a frame sees
    assign cfg.payload = reg_q.payload;
    assign cfg.fd_en = reg_q.fd_en;
    assign cfg.filt_code = reg_q.filt;
    assign cfg.bypass = reg_q.bypass;
    assign cfg.err_dis = reg_q.err_dis;

    swk_filt_map u_filt_map (
        .cfg (cfg.map)
    );

    swk_frame_snap u_snap (
        .core_clk_i (core_clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i (ce_i),
        .soft_rst_i (soft_rst_i),
        .frame_start_i (frame_start_i),
        .cfg (cfg.snap),
        .active_payload_o (wake_payload_o),
        .active_fd_en_o (fd_tolerant_enable_o),
        .active_filt_cycles_o (dominant_filter_cycles_o),
        .active_bypass_o (analog_rx_filter_bypass_o),
        .active_err_cnt_o (error_counter_active_o)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    payload_write_a: assert property (
        ce_i && !soft_rst_i && pay_hit[0] |=> reg_q.payload[0] == $past(reg_wdata_i))
        else $error("payload byte0 write lost");
    reserved_zero_a: assert property (
        ce_i && reg_rd_i && (reg_addr_i == swk_pkg::ADDR_FD_CTRL || reg_addr_i == swk_pkg::ADDR_OPTIONS)
        |=> reg_rdata_o[6] == 1'b0 && (reg_rdata_o[7] == 1'b0 || $past(reg_addr_i) == swk_pkg::ADDR_OPTIONS))
        else $error("reserved bits read nonzero");
    fd_enable_a: assert property (
        ce_i && !soft_rst_i && fd_hit |=> ##1 (($past(ce_i) && $past(frame_start_i) && !$past(soft_rst_i))
        ? fd_tolerant_enable_o == $past(reg_wdata_i[swk_pkg::FD_EN_BIT], 2) : 1'b1))
        else $error("FD enable not applied");
    filt_long_a: assert property (
        cfg.filt_code == swk_pkg::FILT_LONG_CODE |-> cfg.filt_cycles == swk_pkg::FILT_CNT_W'(swk_pkg::FILT_LONG_CYC))
        else $error("long filter time wrong");
    err_gate_a: assert property (
        ce_i && frame_start_i && !soft_rst_i |=> error_counter_active_o == !($past(cfg.err_dis) && $past(cfg.fd_en)))
        else $error("error counter gating wrong");
    silence_clear_a: assert property (
        ce_i && silence_timeout_i && !fd_hit |=> !reg_q.err_dis)
        else $error("silence did not clear disable");
    bypass_snap_a: assert property (
        ce_i && frame_start_i && !soft_rst_i
        |=> analog_rx_filter_bypass_o == $past(cfg.bypass) && dominant_filter_cycles_o == $past(cfg.filt_cycles))
        else $error("bypass or filter not captured");
    trim_lock_a: assert property (
        ce_i && !unlocked |=> $stable(reg_q.fine) && $stable(reg_q.coarse))
        else $error("trim changed while locked");
    rx_select_a: assert property (
        ce_i && unlocked && opt_hit |=> wake_receiver_select_o == $past(reg_wdata_i[swk_pkg::RX_SEL_BIT]))
        else $error("receiver select not written");
    cal_high_a: assert property (
        ce_i && !soft_rst_i ##1 ce_i && reg_rd_i && reg_addr_i == swk_pkg::ADDR_CAL_HIGH
        |=> reg_rdata_o == $past(cal_high_i, 2))
        else $error("calibration high read wrong");
    soft_clear_a: assert property (
        ce_i && soft_rst_i |=> reg_q.payload == '0 && reg_q.cal_h == swk_pkg::BYTE_CLEAR && !reg_q.fd_en)
        else $error("soft reset did not clear");
    frame_hold_a: assert property (
        !(ce_i && (frame_start_i || soft_rst_i)) |=> $stable(wake_payload_o))
        else $error("active payload changed mid frame");
    cal_low_a: assert property (
        ce_i && !soft_rst_i ##1 ce_i && reg_rd_i && reg_addr_i == swk_pkg::ADDR_CAL_LOW
        |=> reg_rdata_o == $past(cal_low_i, 2))
        else $error("calibration low read wrong");
    fine_trim_a: assert property (
        ce_i && unlocked && fine_hit |=> osc_trim_o == {$past(reg_q.coarse), $past(reg_wdata_i)})
        else $error("fine trim not written");
    coarse_trim_a: assert property (
        ce_i && unlocked && opt_hit |=> osc_trim_o == {$past(reg_wdata_i[swk_pkg::COARSE_MSB:0]), $past(reg_q.fine)})
        else $error("coarse trim not written");
    fd_clear_a: assert property (
        ce_i && soft_rst_i |=> reg_q.filt == 3'h0 && !reg_q.bypass && !reg_q.err_dis && error_counter_active_o)
        else $error("soft reset left FD control set");

    // ************************************************************
    // Cover points
    // ************************************************************
    cover_unlock_c: cover property (ce_i && unlocked && opt_hit);
    cover_silence_c: cover property (reg_q.err_dis ##1 ce_i && silence_timeout_i);
    cover_frame_c: cover property (ce_i && fd_hit ##[1:4] ce_i && frame_start_i);
    cover_soft_c: cover property (ce_i && soft_rst_i ##1 ce_i && frame_start_i);
    cover_capture_c: cover property (ce_i && frame_start_i && fd_hit);
endmodule : swk_regs
`default_nettype wire

/* File: tb/swk_bus_model.sv */
// Far-side stand-in: bus event pulses and oscillator calibration result
`timescale 1ns/100ps
`default_nettype none
module swk_bus_model (
    // Requests from the bench
    input wire logic frame_req_i,
    input wire logic silence_req_i,
    input wire logic [15:0] cal_set_i,
    // Device-side events and status
    output logic frame_start_o,
    output logic silence_timeout_o,
    output logic [7:0] cal_high_o,
    output logic [7:0] cal_low_o
);
    // One pulse per bench request, never held between frames
    assign frame_start_o = frame_req_i;
    assign silence_timeout_o = silence_req_i;
    // Calibration held steady so reads never straddle a change
    assign cal_high_o = cal_set_i[15:8];
    assign cal_low_o = cal_set_i[7:0];
endmodule : swk_bus_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the selective-wake register block
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ************************************************************
    // Stimulus and model state
    // ************************************************************
    logic clk, rst, ce, srst, wr, rd, fr_req, sil_req, fstart, sil;
    logic fd_o, byp_o, errc_o, rxs_o;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, cal_h, cal_l;
    logic [1:0] trim_en;
    logic [15:0] cal_set;
    logic [31:0] pay_o;
    logic [swk_pkg::FILT_CNT_W-1:0] filt_o;
    logic [12:0] trim_o;
    integer fails, tests_run, seed, i, a, d, sf, sp, cv;
    integer m [0:127];

    swk_regs dut (.core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .soft_rst_i(srst), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .trim_en_i(trim_en),
        .silence_timeout_i(sil), .frame_start_i(fstart), .cal_high_i(cal_h), .cal_low_i(cal_l),
        .wake_payload_o(pay_o), .fd_tolerant_enable_o(fd_o), .dominant_filter_cycles_o(filt_o),
        .analog_rx_filter_bypass_o(byp_o), .error_counter_active_o(errc_o), .osc_trim_o(trim_o),
        .wake_receiver_select_o(rxs_o));
    swk_bus_model bus (.frame_req_i(fr_req), .silence_req_i(sil_req), .cal_set_i(cal_set),
        .frame_start_o(fstart), .silence_timeout_o(sil), .cal_high_o(cal_h), .cal_low_o(cal_l));

    initial begin
        clk = 1'b0;
        forever #(swk_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic capture;
        cv = 1;
        sf = m[swk_pkg::ADDR_FD_CTRL];
        sp = {m[8'h30][7:0], m[8'h31][7:0], m[8'h32][7:0], m[8'h33][7:0]};
    endtask : capture

    task automatic reg_wr(input logic [6:0] a_i, input logic [7:0] d_i, input logic f_i);
        addr = a_i;
        wdata = d_i;
        wr = 1'b1;
        fr_req = f_i;
        tick();
        wr = 1'b0;
        fr_req = 1'b0;
        tick();
        if (f_i) capture();
        if (!ce) return;
        if (a_i >= swk_pkg::ADDR_PAYLOAD3 && a_i <= swk_pkg::ADDR_PAYLOAD0) m[a_i] = d_i;
        if (a_i == swk_pkg::ADDR_FD_CTRL) m[a_i] = d_i & 8'h3f;
        if (trim_en == swk_pkg::TRIM_UNLOCK && a_i == swk_pkg::ADDR_FINE_TRIM) m[a_i] = d_i;
        if (trim_en == swk_pkg::TRIM_UNLOCK && a_i == swk_pkg::ADDR_OPTIONS) m[a_i] = d_i & 8'h9f;
    endtask : reg_wr

    task automatic reg_rd_chk(input logic [6:0] a_i);
        integer e;
        addr = a_i;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        tick();
        e = m[a_i];
        if (a_i == swk_pkg::ADDR_CAL_HIGH) e = cal_set[15:8];
        if (a_i == swk_pkg::ADDR_CAL_LOW) e = cal_set[7:0];
        check("reg_rdata_o", rdata, e);
    endtask : reg_rd_chk

    task automatic frame_chk;
        integer c;
        c = sf[3:1];
        c = (c == swk_pkg::FILT_LONG_CODE) ? swk_pkg::FILT_LONG_NS : swk_pkg::FILT_STEP_NS * (c + 1);
        c = cv ? (c + swk_pkg::CLK_PERIOD_NS - 1) / swk_pkg::CLK_PERIOD_NS : 0;
        check("fd_tolerant_enable_o", fd_o, sf[0]);
        check("dominant_filter_cycles_o", filt_o, c);
        check("analog_rx_filter_bypass_o", byp_o, sf[4]);
        check("error_counter_active_o", errc_o, !(sf[5] && sf[0]));
        check("wake_payload_o", pay_o, sp);
    endtask : frame_chk

    task automatic frame_pulse;
        fr_req = 1'b1;
        capture();
        tick();
        fr_req = 1'b0;
        tick();
        frame_chk();
    endtask : frame_pulse

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        {rst, ce, srst, wr, rd, fr_req, sil_req} = 7'h60;
        {addr, wdata, trim_en, cal_set, fails, tests_run, sf, sp, cv} = '0;
        for (i = 0; i < 128; i++) m[i] = 0;
        seed = 64640;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        cal_set = 16'($random(seed));
        repeat (3) tick();
        for (a = 8'h2f; a < 8'h3d; a++) reg_rd_chk(a[6:0]);
        frame_chk();
        for (i = 0; i < 150; i++) begin
            a = 8'h30 + ($random(seed) & 15);
            d = $random(seed) & 8'hff;
            trim_en = ($random(seed) & 1) ? 2'h3 : 2'($random(seed));
            if (a == 8'h38) d = (d & 8'h1f) | (m[8'h38] & 8'he0);
            if (a == 8'h39 && d[7] != m[8'h39][7]) d = (d & 8'he0) | (m[8'h39] & 8'h1f);
            reg_wr(a[6:0], d[7:0], 1'b0);
            check("osc_trim_o", trim_o, {m[8'h39][4:0], m[8'h38][7:0]});
            check("wake_receiver_select_o", rxs_o, m[8'h39][7]);
            reg_rd_chk(a[6:0]);
        end
        trim_en = 2'h3;
        reg_wr(swk_pkg::ADDR_OPTIONS, 8'h80 | m[8'h39][4:0], 1'b0);
        check("wake_receiver_select_o", rxs_o, 1'b1);
        for (i = 0; i < 8; i++) begin
            d = (i << 1) | (i & 1) | ((i & 2) << 4) | ((i & 4) << 2);
            reg_wr(swk_pkg::ADDR_FD_CTRL, d[7:0], 1'b0);
            frame_chk();
            frame_pulse();
            reg_wr(swk_pkg::ADDR_FD_CTRL, 8'($random(seed)), 1'b1);
            frame_chk();
        end
        // Writes with the clock enable low are lost
        ce = 1'b0;
        reg_wr(swk_pkg::ADDR_PAYLOAD3, ~m[8'h30][7:0], 1'b0);
        ce = 1'b1;
        reg_rd_chk(swk_pkg::ADDR_PAYLOAD3);
        reg_wr(swk_pkg::ADDR_FD_CTRL, 8'h21, 1'b0);
        sil_req = 1'b1;
        tick();
        sil_req = 1'b0;
        m[swk_pkg::ADDR_FD_CTRL] = 8'h01;
        reg_rd_chk(swk_pkg::ADDR_FD_CTRL);
        frame_pulse();
        srst = 1'b1;
        tick();
        srst = 1'b0;
        for (a = 8'h30; a < 8'h35; a++) m[a] = 0;
        sf = 0;
        sp = 0;
        cv = 0;
        frame_chk();
        repeat (2) tick();
        for (a = 8'h30; a < 8'h3c; a++) reg_rd_chk(a[6:0]);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails = fails + 1;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
